/* rtl/asp_defines.svh */
// constants of the ascii service command port
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
`define ASP_CLK_HZ     25000000
`define ASP_BAUD       19200
`define ASP_BIT_CYC    (`ASP_CLK_HZ / `ASP_BAUD)
`define ASP_CLK_NS     (1000000000 / `ASP_CLK_HZ)
`define ASP_RESP_NS    2000000
`define ASP_RESP_CYC   (`ASP_RESP_NS / `ASP_CLK_NS)
`define ASP_BUF_LEN    32
`define ASP_FIFO_DEPTH 8
`define ASP_CR         8'h0D
`define ASP_SP         8'h20
`define ASP_PR_MAX     8'h7E
`define ASP_DOT        8'h2E
`define ASP_EQ         8'h3D
`define ASP_ZERO       8'h30
`define ASP_NINE       8'h39
`define ASP_ERR        8'h45
`define ASP_L_CFG      8'h43
`define ASP_L_DAT      8'h44
`define ASP_L_SYS      8'h53
`define ASP_L_TAG      8'h54
`define ASP_UNIT_MAX   4'h4
`define ASP_CHAN_MAX   7'h40
`define ASP_PAR_MAX    7'h10
`define ASP_TAG_LEN    5'h10
`define ASP_WORD_RST   16'h0000
`endif

/* rtl/asp_pkg.sv */
// types of the ascii service command port
`default_nettype none
package asp_pkg;
  typedef enum logic [1:0] {CMD_CFG, CMD_DAT, CMD_SYS, CMD_TAG} asp_cmd_t;
  typedef enum logic [1:0] {FLD_CMD, FLD_UNIT, FLD_CHAN, FLD_VAL} asp_fld_t;
  typedef enum logic [1:0] {ST_RECV, ST_EXEC, ST_SEND, ST_DRAIN} asp_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asp_rx_t;
  typedef struct packed {
    asp_cmd_t    cmd;
    asp_fld_t    fld;
    logic [3:0]  unit;
    logic [6:0]  chan;
    logic [16:0] val;
    logic [4:0]  tlen;
    logic [5:0]  len;
    logic        u_seen;
    logic        c_seen;
    logic        v_seen;
    logic        wr;
    logic        bad;
    logic        ovl;
  } asp_par_t;
  typedef struct packed {
    logic        we;
    logic [2:0]  unit;
    logic [5:0]  chan;
    logic [15:0] word;
  } asp_scan_t;
  typedef struct packed {
    logic        vld;
    asp_cmd_t    cmd;
    logic [2:0]  unit;
    logic [6:0]  chan;
    logic [15:0] word;
  } asp_evt_t;
endpackage
`default_nettype wire

/* rtl/asp_port.sv */
// ascii service command port: uart, parser, stores, reply fifo
`default_nettype none
// Function
// - link fixed at 19200 baud, no parity
// - eight data bits, one stop bit
// - carriage return ends every frame
// - non-printable character gives error reply
// - over-long frame gives error reply
// - reply starts within 2 ms
// - spaces skipped, except inside tag value
// - four letters; equals sign means write
// - unit 0..4, unit 0 only S/T
// - channel 1..64
// - parameter number 1..16
// - word value 0..65535
// - setup word stored without meaning check
// - tag holds zero to sixteen characters
// - reply echoes address and word, else error
// - one unit, two channel, five word digits
// - short tag space padded, long rejected
// - gateway tag is unit 0 channel 1
// - sample write updates buffer, scan overwrites
`include "asp_defines.svh"

module asp_fifo #(
  parameter int W = 8,
  parameter int D = `ASP_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         in_vld,
  output logic              in_rdy,
  input  wire logic [W-1:0] in_data,
  output logic              out_vld,
  input  wire logic         out_rdy,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          push, pop;

  // full and empty come straight from the occupancy count
  assign in_rdy   = cnt_ff != CW'(D);
  assign out_vld  = cnt_ff != '0;
  assign out_data = mem[rp_ff];
  assign push     = in_vld && in_rdy;
  assign pop      = out_vld && out_rdy;

  always_comb begin
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
    if (push) nxt_wp = (wp_ff == AW'(D - 1)) ? '0 : wp_ff + 1'b1;
    if (pop) nxt_rp = (rp_ff == AW'(D - 1)) ? '0 : rp_ff + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else if (ce) begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage holds data only, no reset needed
  always_ff @(posedge clk) begin
    if (ce && push) mem[wp_ff] <= in_data;
  end
endmodule

module asp_port #(
  parameter int BIT_CYC  = `ASP_BIT_CYC,
  parameter int RESP_CYC = `ASP_RESP_CYC,
  parameter int BUF_LEN  = `ASP_BUF_LEN
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              rxd,
  input  wire asp_pkg::asp_scan_t scan,
  output logic                   txd,
  output asp_pkg::asp_evt_t      wr_evt
);
  import asp_pkg::*;

  logic [1:0]   rst_sync_ff;
  logic         rst_n;
  asp_rx_t      rx_st_ff, nxt_rx_st;
  logic [15:0]  rx_cnt_ff, nxt_rx_cnt;
  logic [2:0]   rx_bit_ff, nxt_rx_bit;
  logic [7:0]   rx_sh_ff, nxt_rx_sh;
  logic         rx_vld_ff, nxt_rx_vld, rx_err_ff, nxt_rx_err;
  asp_st_t      st_ff, nxt_st;
  asp_par_t     par_ff, nxt_par;
  logic         rep_ok_ff, nxt_rep_ok;
  logic [15:0]  rep_word_ff, nxt_rep_word;
  logic [127:0] rep_tag_ff, nxt_rep_tag, tag_new;
  logic [4:0]   idx_ff, nxt_idx;
  asp_evt_t     evt_ff, nxt_evt;
  logic         tx_busy_ff, nxt_tx_busy, txd_ff, nxt_txd;
  logic [9:0]   tx_sh_ff, nxt_tx_sh;
  logic [15:0]  tx_cnt_ff, nxt_tx_cnt;
  logic [3:0]   tx_bit_ff, nxt_tx_bit;
  logic [7:0]   c, rep_chr, f_data;
  logic         f_rdy, f_vld, f_pop, take, tag_take, ok, is_dig;
  logic [5:0]   ch_m1;
  logic [8:0]   wi;
  logic [6:0]   si;
  logic [7:0]   tbuf [16];
  logic [15:0]  cfg_mem [512];
  logic [15:0]  dat_mem [512];
  logic [15:0]  sys_mem [128];
  logic [127:0] tag_mem [512];

  // reset released through two flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  function automatic logic [16:0] asp_acc(input logic [16:0] a,
                                          input logic [7:0]  d,
                                          input logic [16:0] lim);
    logic [21:0] s;
    s = 22'(a) * 22'h00000A + 22'(d - `ASP_ZERO);
    return (s > 22'(lim)) ? lim : 17'(s);
  endfunction

  function automatic logic [7:0] asp_dig(input logic [15:0] v,
                                         input logic [2:0]  p);
    logic [15:0] d;
    case (p)
      3'h0: d = 16'h2710;
      3'h1: d = 16'h03E8;
      3'h2: d = 16'h0064;
      3'h3: d = 16'h000A;
      default: d = 16'h0001;
    endcase
    return `ASP_ZERO + 8'((v / d) % 16'h000A);
  endfunction

  // receiver samples mid-bit; framing errors mark the byte bad
  always_comb begin
    nxt_rx_st  = rx_st_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh  = rx_sh_ff;
    nxt_rx_err = rx_err_ff;
    nxt_rx_vld = 1'b0;
    if (rx_st_ff != RX_IDLE && rx_cnt_ff != '0) begin
      nxt_rx_cnt = rx_cnt_ff - 16'h0001;
    end else begin
      nxt_rx_cnt = 16'(BIT_CYC - 1);
      case (rx_st_ff)
        RX_IDLE: if (!rxd) begin
          nxt_rx_st  = RX_START;
          nxt_rx_cnt = 16'(BIT_CYC / 2);
        end
        RX_START: begin
          nxt_rx_st  = rxd ? RX_IDLE : RX_DATA;
          nxt_rx_bit = 3'h0;
        end
        RX_DATA: begin
          nxt_rx_sh  = {rxd, rx_sh_ff[7:1]};
          nxt_rx_bit = rx_bit_ff + 3'h1;
          if (rx_bit_ff == 3'h7) nxt_rx_st = RX_STOP;
        end
        default: begin
          nxt_rx_vld = 1'b1;
          nxt_rx_err = !rxd;
          nxt_rx_st  = RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_ff  <= RX_IDLE;
      rx_cnt_ff <= 16'h0000;
      rx_bit_ff <= 3'h0;
      rx_sh_ff  <= 8'h00;
      rx_vld_ff <= 1'b0;
      rx_err_ff <= 1'b0;
    end else if (ce) begin
      rx_st_ff  <= nxt_rx_st;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff  <= nxt_rx_sh;
      rx_vld_ff <= nxt_rx_vld;
      rx_err_ff <= nxt_rx_err;
    end
  end

  // bytes are only taken between frames' replies
  assign c        = rx_sh_ff;
  assign take     = st_ff == ST_RECV && rx_vld_ff;
  assign is_dig   = c >= `ASP_ZERO && c <= `ASP_NINE;
  assign tag_take = take && !rx_err_ff && c >= `ASP_SP && c <= `ASP_PR_MAX
                    && par_ff.fld == FLD_VAL && par_ff.cmd == CMD_TAG;
  assign ch_m1    = 6'(par_ff.chan - 7'h01);
  assign wi       = {par_ff.unit[2:0], ch_m1};
  assign si       = {par_ff.unit[2:0], ch_m1[3:0]};

  // tag bytes past the typed length read as spaces
  for (genvar k = 0; k < 16; k++) begin : g_tag
    assign tag_new[8*k +: 8] = (5'(k) < par_ff.tlen) ? tbuf[k] : `ASP_SP;
  end

  // command legality, checked once the carriage return is in
  always_comb begin
    ok = !par_ff.bad && !par_ff.ovl;
    if (par_ff.wr) ok = ok && (par_ff.cmd == CMD_TAG || par_ff.v_seen);
    else ok = ok && par_ff.fld == FLD_CHAN && par_ff.c_seen;
    if (par_ff.unit > `ASP_UNIT_MAX) ok = 1'b0;
    if (par_ff.unit == 4'h0 && (par_ff.cmd == CMD_CFG
        || par_ff.cmd == CMD_DAT)) ok = 1'b0;
    if (par_ff.chan == 7'h00 || par_ff.chan > (par_ff.cmd == CMD_SYS
        ? `ASP_PAR_MAX : `ASP_CHAN_MAX)) ok = 1'b0;
    if (par_ff.cmd == CMD_TAG && par_ff.unit == 4'h0
        && par_ff.chan != 7'h01) ok = 1'b0;
    if (par_ff.cmd == CMD_TAG && par_ff.tlen > `ASP_TAG_LEN)
      ok = 1'b0;
    if (par_ff.cmd != CMD_TAG && par_ff.val[16]) ok = 1'b0;
  end

  // reply text, one character per index
  always_comb begin
    rep_chr = `ASP_CR;
    if (!rep_ok_ff) begin
      if (idx_ff == 5'h00) rep_chr = `ASP_ERR;
    end else begin
      case (idx_ff)
        5'h00: case (par_ff.cmd)
          CMD_CFG: rep_chr = `ASP_L_CFG;
          CMD_DAT: rep_chr = `ASP_L_DAT;
          CMD_SYS: rep_chr = `ASP_L_SYS;
          default: rep_chr = `ASP_L_TAG;
        endcase
        5'h01: rep_chr = `ASP_ZERO + {4'h0, par_ff.unit};
        5'h02: rep_chr = `ASP_DOT;
        5'h03: rep_chr = `ASP_ZERO + 8'(par_ff.chan / 7'h0A);
        5'h04: rep_chr = `ASP_ZERO + 8'(par_ff.chan % 7'h0A);
        5'h05: rep_chr = `ASP_EQ;
        default: begin
          if (par_ff.cmd == CMD_TAG) begin
            if (idx_ff <= 5'h15) rep_chr = rep_tag_ff[8*(idx_ff-5'h06) +: 8];
          end else if (idx_ff <= 5'h0A) begin
            rep_chr = asp_dig(rep_word_ff, 3'(idx_ff - 5'h06));
          end
        end
      endcase
    end
  end

  // frame parser and reply sequencer
  always_comb begin
    nxt_st       = st_ff;
    nxt_par      = par_ff;
    nxt_rep_ok   = rep_ok_ff;
    nxt_rep_word = rep_word_ff;
    nxt_rep_tag  = rep_tag_ff;
    nxt_idx      = idx_ff;
    nxt_evt      = '0;
    case (st_ff)
      ST_RECV: if (take) begin
        if (par_ff.len != 6'h3F) nxt_par.len = par_ff.len + 6'h01;
        if (c == `ASP_CR) begin
          nxt_st = ST_EXEC;
        end else if (par_ff.len >= 6'(BUF_LEN)) begin
          nxt_par.ovl = 1'b1;
        end else if (rx_err_ff || c < `ASP_SP || c > `ASP_PR_MAX) begin
          nxt_par.bad = 1'b1;
        end else if (tag_take) begin
          if (par_ff.tlen <= `ASP_TAG_LEN)
            nxt_par.tlen = par_ff.tlen + 5'h01;
        end else if (c != `ASP_SP) begin
          case (par_ff.fld)
            FLD_CMD: begin
              nxt_par.fld = FLD_UNIT;
              case (c)
                `ASP_L_CFG: nxt_par.cmd = CMD_CFG;
                `ASP_L_DAT: nxt_par.cmd = CMD_DAT;
                `ASP_L_SYS: nxt_par.cmd = CMD_SYS;
                `ASP_L_TAG: nxt_par.cmd = CMD_TAG;
                default: nxt_par.bad = 1'b1;
              endcase
            end
            FLD_UNIT: if (is_dig) begin
              nxt_par.unit = 4'(asp_acc(17'(par_ff.unit), c, 17'h0000F));
              nxt_par.u_seen = 1'b1;
            end else if (c == `ASP_DOT && par_ff.u_seen) begin
              nxt_par.fld = FLD_CHAN;
            end else nxt_par.bad = 1'b1;
            FLD_CHAN: if (is_dig) begin
              nxt_par.chan = 7'(asp_acc(17'(par_ff.chan), c, 17'h0007F));
              nxt_par.c_seen = 1'b1;
            end else if (c == `ASP_EQ && par_ff.c_seen) begin
              nxt_par.fld = FLD_VAL;
              nxt_par.wr  = 1'b1;
            end else nxt_par.bad = 1'b1;
            default: if (is_dig) begin
              nxt_par.val = asp_acc(par_ff.val, c, 17'h10000);
              nxt_par.v_seen = 1'b1;
            end else nxt_par.bad = 1'b1;
          endcase
        end
      end
      ST_EXEC: begin
        nxt_rep_ok = ok;
        nxt_idx    = 5'h00;
        nxt_st     = ST_SEND;
        case (par_ff.cmd)
          CMD_CFG: nxt_rep_word = cfg_mem[wi];
          CMD_DAT: nxt_rep_word = dat_mem[wi];
          default: nxt_rep_word = sys_mem[si];
        endcase
        nxt_rep_tag = par_ff.wr ? tag_new : tag_mem[wi];
        if (par_ff.wr) nxt_rep_word = par_ff.val[15:0];
        if (ok && par_ff.wr && par_ff.cmd != CMD_TAG) begin
          nxt_evt.vld  = 1'b1;
          nxt_evt.cmd  = par_ff.cmd;
          nxt_evt.unit = par_ff.unit[2:0];
          nxt_evt.chan = par_ff.chan;
          nxt_evt.word = par_ff.val[15:0];
        end
      end
      ST_SEND: if (f_rdy) begin
        nxt_idx = idx_ff + 5'h01;
        if (rep_chr == `ASP_CR) nxt_st = ST_DRAIN;
      end
      default: if (!f_vld && !tx_busy_ff) begin
        nxt_st  = ST_RECV;
        nxt_par = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff       <= ST_RECV;
      par_ff      <= '0;
      rep_ok_ff   <= 1'b0;
      rep_word_ff <= `ASP_WORD_RST;
      rep_tag_ff  <= '0;
      idx_ff      <= 5'h00;
      evt_ff      <= '0;
    end else if (ce) begin
      st_ff       <= nxt_st;
      par_ff      <= nxt_par;
      rep_ok_ff   <= nxt_rep_ok;
      rep_word_ff <= nxt_rep_word;
      rep_tag_ff  <= nxt_rep_tag;
      idx_ff      <= nxt_idx;
      evt_ff      <= nxt_evt;
    end
  end

  // stores; a scan write lands after a command write so live data wins
  always_ff @(posedge clk) begin
    if (ce && tag_take && par_ff.tlen < `ASP_TAG_LEN)
      tbuf[par_ff.tlen[3:0]] <= c;
    if (ce && st_ff == ST_EXEC && ok && par_ff.wr) begin
      case (par_ff.cmd)
        CMD_CFG: cfg_mem[wi] <= par_ff.val[15:0];
        CMD_DAT: dat_mem[wi] <= par_ff.val[15:0];
        CMD_SYS: sys_mem[si] <= par_ff.val[15:0];
        default: tag_mem[wi] <= tag_new;
      endcase
    end
    if (ce && scan.we) dat_mem[{scan.unit, scan.chan}] <= scan.word;
  end

  // reply fifo lets the formatter run ahead of the slow line
  asp_fifo #(.W(8), .D(`ASP_FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .in_vld   (st_ff == ST_SEND),
    .in_rdy   (f_rdy),
    .in_data  (rep_chr),
    .out_vld  (f_vld),
    .out_rdy  (!tx_busy_ff),
    .out_data (f_data)
  );
  assign f_pop = f_vld && !tx_busy_ff;

  // transmitter: start, eight data, one stop, no parity
  always_comb begin
    nxt_tx_busy = tx_busy_ff;
    nxt_tx_sh   = tx_sh_ff;
    nxt_tx_cnt  = tx_cnt_ff;
    nxt_tx_bit  = tx_bit_ff;
    if (f_pop) begin
      nxt_tx_busy = 1'b1;
      nxt_tx_sh   = {1'b1, f_data, 1'b0};
      nxt_tx_cnt  = 16'(BIT_CYC - 1);
      nxt_tx_bit  = 4'h0;
    end else if (tx_busy_ff && tx_cnt_ff != '0) begin
      nxt_tx_cnt = tx_cnt_ff - 16'h0001;
    end else if (tx_busy_ff) begin
      nxt_tx_sh   = {1'b1, tx_sh_ff[9:1]};
      nxt_tx_cnt  = 16'(BIT_CYC - 1);
      nxt_tx_bit  = tx_bit_ff + 4'h1;
      if (tx_bit_ff == 4'h9) nxt_tx_busy = 1'b0;
    end
    nxt_txd = nxt_tx_busy ? nxt_tx_sh[0] : 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_ff <= 1'b0;
      tx_sh_ff   <= 10'h3FF;
      tx_cnt_ff  <= 16'h0000;
      tx_bit_ff  <= 4'h0;
      txd_ff     <= 1'b1;
    end else if (ce) begin
      tx_busy_ff <= nxt_tx_busy;
      tx_sh_ff   <= nxt_tx_sh;
      tx_cnt_ff  <= nxt_tx_cnt;
      tx_bit_ff  <= nxt_tx_bit;
      txd_ff     <= nxt_txd;
    end
  end

  assign txd    = txd_ff;
  assign wr_evt = evt_ff;

  // helper: cycles from accepted carriage return to first start bit
  logic [31:0] resp_cnt_ff;
  logic        resp_on_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_on_ff  <= 1'b0;
      resp_cnt_ff <= '0;
    end else begin
      if (take && c == `ASP_CR) resp_on_ff <= 1'b1;
      else if (f_pop) resp_on_ff <= 1'b0;
      resp_cnt_ff <= resp_on_ff ? resp_cnt_ff + 32'h1 : '0;
    end
  end

  sequence s_cr_in;
    take && c == `ASP_CR;
  endsequence
  sequence s_exec_send;
    st_ff == ST_EXEC ##1 st_ff == ST_SEND;
  endsequence

  property p_frame_end;
    @(posedge clk) disable iff (!rst_n || !ce) s_cr_in |=> s_exec_send;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("no exec");

  property p_bad_char;
    @(posedge clk) disable iff (!rst_n || !ce)
      take && c < `ASP_SP && c != `ASP_CR |=> par_ff.bad || par_ff.ovl;
  endproperty
  a_bad_char: assert property (p_bad_char) else $error("char kept");

  property p_overlen;
    @(posedge clk) disable iff (!rst_n || !ce)
      take && c != `ASP_CR && par_ff.len >= 6'(BUF_LEN) |=> par_ff.ovl;
  endproperty
  a_overlen: assert property (p_overlen) else $error("no ovl");

  property p_err_reply;
    @(posedge clk) disable iff (!rst_n || !ce)
      st_ff == ST_EXEC && (par_ff.ovl || par_ff.bad) |=> !rep_ok_ff;
  endproperty
  a_err_reply: assert property (p_err_reply) else $error("no error");

  property p_resp_time;
    @(posedge clk) disable iff (!rst_n) resp_cnt_ff < 32'(RESP_CYC);
  endproperty
  a_resp_time: assert property (p_resp_time) else $error("slow reply");

  property p_discard;
    @(posedge clk) disable iff (!rst_n || !ce)
      st_ff != ST_RECV && rx_vld_ff |=> $stable(par_ff.len);
  endproperty
  a_discard: assert property (p_discard) else $error("byte taken");

  property p_space;
    @(posedge clk) disable iff (!rst_n || !ce)
      take && c == `ASP_SP && par_ff.fld != FLD_VAL && !rx_err_ff
      && !par_ff.bad |=> $stable(par_ff.fld) && !par_ff.bad;
  endproperty
  a_space: assert property (p_space) else $error("space used");

  property p_unit0;
    @(posedge clk) disable iff (!rst_n || !ce)
      st_ff == ST_EXEC && par_ff.unit == 4'h0 && par_ff.cmd == CMD_DAT
      |=> !rep_ok_ff;
  endproperty
  a_unit0: assert property (p_unit0) else $error("unit 0 taken");

  property p_chan;
    @(posedge clk) disable iff (!rst_n || !ce)
      st_ff == ST_EXEC && par_ff.chan > `ASP_CHAN_MAX |=> !rep_ok_ff;
  endproperty
  a_chan: assert property (p_chan) else $error("chan taken");

  property p_word;
    @(posedge clk) disable iff (!rst_n || !ce)
      st_ff == ST_EXEC && par_ff.cmd != CMD_TAG && par_ff.val[16]
      |=> !rep_ok_ff && !evt_ff.vld;
  endproperty
  a_word: assert property (p_word) else $error("word taken");
endmodule
`default_nettype wire

/* test/asp_host_model.sv */
// serial host model: sends command frames, collects replies
`default_nettype none
module asp_host_model #(
  parameter int BIT_CYC = 8,
  parameter int CLK_NS  = 40
) (
  input  wire logic clk,
  output logic      rxd,
  input  wire logic txd
);
  timeunit 1ns;
  timeprecision 1ps;
  string      rbuf = "";
  string      reply = "";
  int         n_rep = 0;
  int         lat = 0;
  time        t_end = 0;
  logic [7:0] ch;
  initial rxd = 1'b1;
  // start bit, eight data bits lsb first, one stop bit, no parity
  task automatic send_str(input string s);
    logic [9:0] fr;
    foreach (s[i]) begin
      fr = {1'b1, s[i], 1'b0};
      for (int b = 0; b < 10; b++) begin
        rxd = fr[b];
        // the reply may start inside our own last stop bit, so the
        // latency origin is set before that bit goes out
        if (b == 9) t_end = $time + BIT_CYC * CLK_NS;
        repeat (BIT_CYC) @(negedge clk);
      end
    end
  endtask
  // receiver samples mid-bit; a bad stop bit shows up as '?'
  initial forever begin
    @(negedge clk);
    if (txd === 1'b0) begin
      if (rbuf.len() == 0) lat = (int'($time) - int'(t_end)) / CLK_NS;
      repeat (BIT_CYC / 2) @(negedge clk);
      for (int b = 0; b < 8; b++) begin
        repeat (BIT_CYC) @(negedge clk);
        ch[b] = txd;
      end
      repeat (BIT_CYC) @(negedge clk);
      if (txd !== 1'b1) ch = 8'h3F;
      rbuf = $sformatf("%s%c", rbuf, ch);
      if (ch == 8'h0D) begin
        reply = rbuf;
        rbuf = "";
        n_rep++;
      end
    end
  end
endmodule
`default_nettype wire

/* test/asp_port_tb.sv */
// self-checking bench for the ascii service command port
`default_nettype none
module asp_port_tb;
  import asp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC = 1000;
  logic        clk = 1'b0;
  logic        rstn;
  logic        ce;
  logic        rxd;
  logic        txd;
  asp_scan_t   scan;
  asp_evt_t    wr_evt;
  asp_evt_t    last_evt;
  int          n_evt = 0;
  int          err_total = 0;
  int          n_checks = 0;
  logic [31:0] lfsr = 32'hB34E;
  string       bad[$];
  string       s;
  int          u, c, w, k;

  always #20 clk = ~clk;
  asp_port #(.BIT_CYC(8), .RESP_CYC(RC), .BUF_LEN(32)) dut (
    .clk(clk), .rstn(rstn), .ce(ce), .rxd(rxd), .scan(scan),
    .txd(txd), .wr_evt(wr_evt));
  asp_host_model #(.BIT_CYC(8)) host (.clk(clk), .rxd(rxd), .txd(txd));

  // keep the latest write event and count them
  always @(posedge clk) begin
    if (wr_evt.vld === 1'b1) begin
      last_evt <= wr_evt;
      n_evt <= n_evt + 1;
    end
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic string wrep(string l, int u, int c, int w);
    return $sformatf("%s%0d.%02d=%05d\r", l, u, c, w);
  endfunction
  function automatic string pad(string t, int n);
    while (t.len() < n) t = {t, " "};
    return t;
  endfunction
  function automatic string tag(string t);
    return {pad({"T0.01=", t}, 22), "\r"};
  endfunction

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic cmp_evt(input asp_evt_t e);
    chk(last_evt === e, "write event");
  endtask
  // one frame, bounded wait for its reply, then reply/latency/event
  task automatic cmd(input string f, input string exp, input int wr);
    int n0;
    int e0;
    int t;
    n0 = host.n_rep;
    e0 = n_evt;
    host.send_str({f, "\r"});
    t = 0;
    while (host.n_rep == n0 && t < 5000) begin
      @(negedge clk);
      t++;
    end
    chk(host.n_rep != n0, {"no reply to ", f});
    chk(host.reply == exp, {"reply to ", f});
    chk(host.lat < RC, "reply late");
    chk(n_evt - e0 == wr, "event count");
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: the run needs well under this many cycles
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  // main sequence: corners, error table, random writes, scan, drop
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    scan = '0;
    bad = '{"C0.1=5", "D5.1", "D1.0", "D1.65", "S0.0", "S0.17",
      "C1.1=65536", "Q1.1", $sformatf("D1.1%c", 8'h01),
      $sformatf("D1.%c1", 8'h7F), pad("D1.1", 33)};
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    cmd("D1.4=5400", wrep("D", 1, 4, 5400), 1);
    cmp_evt('{1'b1, CMD_DAT, 3'd1, 7'd4, 16'd5400});
    cmd("D1.4", wrep("D", 1, 4, 5400), 0);
    cmd("C 1 . 4 = 1234", wrep("C", 1, 4, 1234), 1);
    cmd("S0.16=65535", wrep("S", 0, 16, 65535), 1);
    cmd("S0.1=0", wrep("S", 0, 1, 0), 1);
    cmd("D4.64=7", wrep("D", 4, 64, 7), 1);
    cmd(pad("D4.64", 32), wrep("D", 4, 64, 7), 0);
    cmd("T0.1=Ab", tag("Ab"), 0);
    cmd("T0.1= x y", tag(" x y"), 0);
    cmd("T0.1=", tag(""), 0);
    cmd("T0.1=ABCDEFGHIJKLMNOPQ", "E\r", 0);
    cmd("T0.1", tag(""), 0);
    foreach (bad[i]) cmd(bad[i], "E\r", 0);
    repeat (6) begin
      k = rnd() % 2;
      u = 1 + rnd() % 4;
      c = 1 + rnd() % 64;
      w = rnd() % 65536;
      s = k ? "D" : "C";
      cmd($sformatf("%s%0d.%0d=%0d", s, u, c, w), wrep(s, u, c, w), 1);
      cmp_evt('{1'b1, asp_cmd_t'(k), 3'(u), 7'(c), 16'(w)});
    end
    cmd("D2.10=5", wrep("D", 2, 10, 5), 1);
    scan = '{1'b1, 3'd2, 6'd9, 16'd777};
    @(negedge clk);
    scan.we = 1'b0;
    cmd("D2.10", wrep("D", 2, 10, 777), 0);
    k = host.n_rep;
    host.send_str("D1.4\rD1.4\r");
    repeat (2500) @(negedge clk);
    chk(host.n_rep == k + 1, "frame during reply kept");
    cmd("D2.10", wrep("D", 2, 10, 777), 0);
    wrap_up();
  end
endmodule
`default_nettype wire
